// File: memmap_pkg.sv
// Contract
// R01 - program counter is 13 bits, addressing 8K words of 14 bits
// R02 - small variant implements only program words 0000h to 03FFh
// R03 - large variant implements program words 0000h to 07FFh
// R04 - fetches above implemented space wrap by dropping upper address bits
// R05 - program counter starts at 0000h after reset
// R06 - taken interrupt loads program counter with vector 0004h
// R07 - two data banks; first 32 locations of each are special registers
// R08 - small variant: bank 0 locations 40h to 7Fh are general RAM
// R09 - large variant: RAM at bank 0 20h-7Fh and bank 1 A0h-EFh
// R10 - bank 1 F0h-FFh reach the same storage as bank 0 70h-7Fh
// R11 - reads of unimplemented data locations return zero
// R12 - bank select bit 0 picks bank 0, 1 picks bank 1
// R13 - software keeps the two reserved bank bits at zero
// R14 - every general register reachable directly and through the file pointer
// R15 - direct address is bank select bit joined above 7-bit instruction field
package memmap_pkg;

    // ------------------------------------------------------------
    // program memory
    // ------------------------------------------------------------
    localparam int          PC_W        = 13;
    localparam int          INSTR_W     = 14;
    localparam int          PROG_AW_S   = 10;      // 1K words
    localparam int          PROG_AW_L   = 11;      // 2K words
    localparam logic [12:0] RESET_VEC   = 13'h0000;
    localparam logic [12:0] IRQ_VEC     = 13'h0004;

    // ------------------------------------------------------------
    // data memory
    // ------------------------------------------------------------
    localparam int          DATA_W      = 8;
    localparam int          DADDR_W     = 8;
    localparam int          DIR_W       = 7;
    localparam logic [6:0]  SFR_TOP     = 7'h1F;   // last special location in a bank
    localparam logic [6:0]  GPR_LO_S    = 7'h40;
    localparam logic [6:0]  GPR_LO_L    = 7'h20;
    localparam logic [6:0]  B1_GPR_LO   = 7'h20;   // A0h within bank 1
    localparam logic [6:0]  B1_GPR_HI   = 7'h6F;   // EFh within bank 1
    localparam logic [6:0]  MIRROR_LO   = 7'h70;   // F0h-FFh / 70h-7Fh
    localparam int          RAM_DEPTH   = 256;     // bank 1 words keep their own address

    // kinds of data access
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_SFR,
        KIND_GPR
    } dkind_e;

    // decoded data location
    typedef struct packed {
        dkind_e     kind;
        logic [7:0] sfr_addr;  // bank bit plus 7-bit offset
        logic [7:0] ram_idx;   // physical RAM word
    } ddec_s;

endpackage

// File: memory_map_bank_decoder.sv
`timescale 1ns/1ps
module memory_map_bank_decoder #(
    parameter bit LARGE = 1'b0                          // 1 selects the 2K / 176-byte variant
) (
    input  wire logic        core_clk,                  // core clock, 100 MHz
    input  wire logic        rst_n,                     // async reset, active low
    input  wire logic        pc_load,                   // load program counter from pc_load_val
    input  wire logic [12:0] pc_load_val,               // jump target
    input  wire logic        pc_inc,                    // advance program counter
    input  wire logic        irq_take,                  // interrupt taken this cycle
    input  wire logic [13:0] prog_rdata,                // word from program store
    output logic      [12:0] pc,                        // program counter
    output logic      [10:0] prog_addr,                 // physical program address
    output logic      [13:0] instr,                     // fetched word, registered
    input  wire logic        bank_select_bit,           // status bank select
    input  wire logic        reserved_bank_bit_high,    // reserved, expected zero
    input  wire logic        indirect_bank_bit,         // reserved, expected zero
    input  wire logic [7:0]  file_select_pointer,       // indirect pointer
    input  wire logic        use_indirect,              // 1 addresses through the pointer
    input  wire logic [6:0]  dir_addr,                  // 7-bit field of the instruction
    input  wire logic        d_rd,                      // data read strobe
    input  wire logic        d_wr,                      // data write strobe
    input  wire logic [7:0]  d_wdata,                   // write data
    output logic      [7:0]  d_rdata,                   // read data, registered
    output logic             sfr_sel,                   // access goes to special registers
    output logic      [7:0]  sfr_addr,                  // special register address
    input  wire logic [7:0]  sfr_rdata,                 // data from special registers
    output logic             rsvd_bits_set              // reserved bank bits found nonzero
);

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    // one decoder serves both direct and indirect paths
    function automatic memmap_pkg::ddec_s dec(input logic [7:0] a);
        memmap_pkg::ddec_s d;
        logic [6:0]        o;
        o          = a[6:0];
        d.kind     = memmap_pkg::KIND_NONE;
        d.sfr_addr = a;
        d.ram_idx  = {1'b0, o};
        // R07 special region
        if (o <= memmap_pkg::SFR_TOP) begin
            d.kind = memmap_pkg::KIND_SFR;
        end else if (!a[7]) begin
            // R08 R09 bank 0 range
            if (o >= (LARGE ? memmap_pkg::GPR_LO_L : memmap_pkg::GPR_LO_S))
                d.kind = memmap_pkg::KIND_GPR;
        end else if (o >= memmap_pkg::MIRROR_LO) begin
            // R10 bank 1 top mirrors bank 0
            d.kind = memmap_pkg::KIND_GPR;
        end else if (LARGE && o >= memmap_pkg::B1_GPR_LO && o <= memmap_pkg::B1_GPR_HI) begin
            // R09 bank 1 RAM kept apart
            // packing it below 80h would alias bank 0 words 20h-6Fh
            d.kind    = memmap_pkg::KIND_GPR;
            d.ram_idx = a;
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    logic [12:0] pc_ff, nxt_pc;
    logic [13:0] instr_ff, nxt_instr;

    // interrupt wins over a jump, jump over increment
    always_comb begin
        nxt_pc    = pc_ff;
        nxt_instr = prog_rdata;
        // R06 interrupt vector
        if (irq_take)
            nxt_pc = memmap_pkg::IRQ_VEC;
        else if (pc_load)
            nxt_pc = pc_load_val;
        else if (pc_inc)
            nxt_pc = 13'(pc_ff + 13'h0001);  // R01 13-bit wrap
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // R05 reset vector
            pc_ff    <= memmap_pkg::RESET_VEC;
            instr_ff <= 14'h0000;
        end else begin
            pc_ff    <= nxt_pc;
            instr_ff <= nxt_instr;
        end
    end

    assign pc    = pc_ff;
    assign instr = instr_ff;
    // R02 R03 R04 upper bits ignored, so fetches wrap into the implemented space
    assign prog_addr = LARGE ? pc_ff[memmap_pkg::PROG_AW_L-1:0]
                             : {1'b0, pc_ff[memmap_pkg::PROG_AW_S-1:0]};

    // ------------------------------------------------------------
    // data address decode
    // ------------------------------------------------------------
    logic [7:0]        daddr;
    memmap_pkg::ddec_s dd;

    // R15 R14 R12 direct address takes the bank bit on top, else the pointer
    assign daddr    = use_indirect ? file_select_pointer : {bank_select_bit, dir_addr};
    assign dd       = dec(daddr);
    assign sfr_sel  = (d_rd || d_wr) && dd.kind == memmap_pkg::KIND_SFR;
    assign sfr_addr = dd.sfr_addr;
    // R13 flag software that breaks the reserved-bit convention
    assign rsvd_bits_set = reserved_bank_bit_high | indirect_bank_bit;

    // ------------------------------------------------------------
    // general register storage
    // ------------------------------------------------------------
    // a full 256-word array; the small variant never decodes most of it
    logic [7:0] ram [memmap_pkg::RAM_DEPTH];
    logic [7:0] rdata_ff, nxt_rdata;

    always_ff @(posedge core_clk) begin
        if (d_wr && dd.kind == memmap_pkg::KIND_GPR)
            ram[dd.ram_idx] <= d_wdata;
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (d_rd) begin
            case (dd.kind)
                memmap_pkg::KIND_GPR: nxt_rdata = ram[dd.ram_idx];
                memmap_pkg::KIND_SFR: nxt_rdata = sfr_rdata;
                // R11 unimplemented reads zero
                default:              nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign d_rdata = rdata_ff;

    // ------------------------------------------------------------
    // assertions, program side
    // ------------------------------------------------------------
    // R06 interrupt vector load
    AST_PC_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_take |=> pc == memmap_pkg::IRQ_VEC)  // R06
        else $error("pc not at interrupt vector");

    // R01 counter advance
    AST_PC_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_inc && !pc_load && !irq_take |=> pc == 13'($past(pc) + 13'h0001))  // R01
        else $error("pc did not advance");

    // R04 wrap by truncation
    AST_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        prog_addr[9:0] == pc[9:0] && (LARGE || !prog_addr[10]))  // R04
        else $error("program address does not wrap");

    // R05 reset vector
    AST_RESET_PC: assert property (@(posedge core_clk)
        $rose(rst_n) |-> pc == memmap_pkg::RESET_VEC)  // R05
        else $error("pc not zero after reset");

    // R05 outputs clear after reset
    AST_RESET_OUT: assert property (@(posedge core_clk)
        $rose(rst_n) |-> instr == 14'h0000 && d_rdata == 8'h00)  // R05
        else $error("outputs not clear after reset");

    // R01 jump target taken
    AST_PC_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_load && !irq_take |=> pc == $past(pc_load_val))  // R01
        else $error("pc did not take jump target");

    // R01 idle counter holds
    AST_PC_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pc_inc && !pc_load && !irq_take |=> pc == $past(pc))  // R01
        else $error("pc moved without request");

    // R02 small space bound
    AST_SMALL_SPACE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !LARGE |-> !prog_addr[memmap_pkg::PROG_AW_S])  // R02
        else $error("small variant leaves 1K space");

    // R03 large space kept
    AST_LARGE_SPACE: assert property (@(posedge core_clk) disable iff (!rst_n)
        LARGE |-> prog_addr == pc[memmap_pkg::PROG_AW_L-1:0])  // R03
        else $error("large variant loses 2K address bit");

    // R04 fetched word follows address
    AST_INSTR_LAG: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> instr == $past(prog_rdata))  // R04
        else $error("fetched word not registered");

    // ------------------------------------------------------------
    // assertions, data side
    // ------------------------------------------------------------
    // R07 low offsets special
    AST_SFR_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        (d_rd && daddr[6:0] <= memmap_pkg::SFR_TOP) |-> sfr_sel)  // R07
        else $error("low location not special");

    // R07 upper offsets not special
    AST_SFR_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        daddr[6:0] > memmap_pkg::SFR_TOP |-> !sfr_sel)  // R07
        else $error("upper location marked special");

    // R07 special address passes through
    AST_SFR_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
        sfr_sel |-> sfr_addr == daddr)  // R07
        else $error("special address not passed through");

    // R07 special read data
    AST_SFR_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        d_rd && sfr_sel |=> d_rdata == $past(sfr_rdata))  // R07
        else $error("special read data lost");

    // R11 unimplemented reads zero
    AST_UNIMP_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        (d_rd && dd.kind == memmap_pkg::KIND_NONE) |=> d_rdata == 8'h00)  // R11
        else $error("unimplemented read not zero");

    // R11 small bank 1 gap
    AST_SMALL_B1: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!LARGE && daddr[7] && daddr[6:0] > memmap_pkg::SFR_TOP && daddr[6:0] < memmap_pkg::MIRROR_LO)
        |-> dd.kind == memmap_pkg::KIND_NONE)  // R11
        else $error("small variant decodes bank 1 gap");

    // R10 mirror index
    AST_MIRROR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (daddr[7] && daddr[6:0] >= memmap_pkg::MIRROR_LO) |-> dd.ram_idx == {1'b0, daddr[6:0]})  // R10
        else $error("mirror index wrong");

    // R15 direct address form
    AST_BANK_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        !use_indirect |-> daddr[7] == bank_select_bit && daddr[6:0] == dir_addr)  // R15
        else $error("direct address malformed");

    // R14 pointer path
    AST_INDIRECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        use_indirect |-> daddr == file_select_pointer)  // R14
        else $error("pointer address not used");

    // R08 small gap unused
    AST_SMALL_GAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!LARGE && !daddr[7] && daddr[6:5] == 2'h1) |-> dd.kind == memmap_pkg::KIND_NONE)  // R08
        else $error("small variant decodes 20h-3Fh");

    // R08 small bank 0 RAM
    AST_SMALL_B0: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!LARGE && !daddr[7] && daddr[6]) |-> dd.kind == memmap_pkg::KIND_GPR)  // R08
        else $error("small variant misses 40h-7Fh");

    // R08 bank 0 index
    AST_B0_IDX: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dd.kind == memmap_pkg::KIND_GPR && !daddr[7]) |-> dd.ram_idx == {1'b0, daddr[6:0]})  // R08
        else $error("bank 0 index wrong");

    // R09 large bank 0 RAM
    AST_LARGE_B0: assert property (@(posedge core_clk) disable iff (!rst_n)
        (LARGE && !daddr[7] && daddr[6:0] > memmap_pkg::SFR_TOP) |-> dd.kind == memmap_pkg::KIND_GPR)  // R09
        else $error("large variant misses 20h-7Fh");

    // R09 large bank 1 RAM
    AST_LARGE_B1: assert property (@(posedge core_clk) disable iff (!rst_n)
        (LARGE && daddr[7] && daddr[6:0] >= memmap_pkg::B1_GPR_LO && daddr[6:0] <= memmap_pkg::B1_GPR_HI)
        |-> dd.kind == memmap_pkg::KIND_GPR && dd.ram_idx == daddr)  // R09
        else $error("large variant misses A0h-EFh");

    // R09 bank 1 storage apart
    AST_NO_ALIAS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dd.kind == memmap_pkg::KIND_GPR && daddr[7] && daddr[6:0] < memmap_pkg::MIRROR_LO)
        |-> dd.ram_idx[7])  // R09
        else $error("bank 1 word aliases bank 0");

    // R11 idle read data holds
    AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !d_rd |=> d_rdata == $past(d_rdata))  // R11
        else $error("read data changed without read");

    // R14 write then read back
    AST_RAM_BACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (d_wr && dd.kind == memmap_pkg::KIND_GPR && !d_rd) ##1
        (d_rd && !d_wr && dd.kind == memmap_pkg::KIND_GPR && dd.ram_idx == $past(dd.ram_idx))
        |=> d_rdata == $past(d_wdata, 2))  // R14
        else $error("ram read-back mismatch");

    COV_IRQ:    cover property (@(posedge core_clk) disable iff (!rst_n) irq_take);
    COV_MIRROR: cover property (@(posedge core_clk) disable iff (!rst_n) d_rd && daddr[7] && daddr[6:4] == 3'h7);
    COV_IND:    cover property (@(posedge core_clk) disable iff (!rst_n) use_indirect && d_wr);
    COV_UNIMP:  cover property (@(posedge core_clk) disable iff (!rst_n) d_rd && dd.kind == memmap_pkg::KIND_NONE);

endmodule

// File: core_side_store.sv
`timescale 1ns/1ps
// ----------------------------------------
// program store and special register file
// ----------------------------------------
module core_side_store (
    input  wire logic [10:0] prog_addr,  // physical program address
    input  wire logic [7:0]  sfr_addr,   // special register address
    output logic      [13:0] prog_rdata, // program word
    output logic      [7:0]  sfr_rdata   // special register data
);
    // words are tagged with their own address so a wrong fetch shows up
    assign prog_rdata = {3'h5, prog_addr};
    assign sfr_rdata  = sfr_addr ^ 8'hC3;
endmodule

// File: memory_map_bank_decoder_test.sv
`timescale 1ns/1ps
module memory_map_bank_decoder_test;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pc_load = 1'b0, pc_inc = 1'b0, irq_take = 1'b0;
    logic [12:0] pc_load_val = 13'h0000, pc;
    logic [13:0] prog_rdata, instr;
    logic [10:0] prog_addr;
    logic        bank_select_bit = 1'b0, reserved_bank_bit_high = 1'b0, indirect_bank_bit = 1'b0;
    logic [7:0]  file_select_pointer = 8'h00, d_wdata = 8'h00, d_rdata, sfr_addr, sfr_rdata;
    logic        use_indirect = 1'b0, d_rd = 1'b0, d_wr = 1'b0, sfr_sel, rsvd_bits_set;
    logic [6:0]  dir_addr = 7'h00;
    logic [12:0] pc_l;
    logic [13:0] prog_rdata_l, instr_l;
    logic [10:0] prog_addr_l;
    logic [7:0]  d_rdata_l, sfr_addr_l, sfr_rdata_l;
    logic        sfr_sel_l, rsvd_l;
    int          n_mismatch = 0, n_compared = 0, cycles = 0;

    // clock, 100 MHz
    always #5 core_clk = ~core_clk;

    memory_map_bank_decoder #(.LARGE(1'b0)) memory_map_bank_decoder_i (.core_clk(core_clk), .rst_n(rst_n),
        .pc_load(pc_load), .pc_load_val(pc_load_val), .pc_inc(pc_inc), .irq_take(irq_take),
        .prog_rdata(prog_rdata), .pc(pc), .prog_addr(prog_addr), .instr(instr),
        .bank_select_bit(bank_select_bit), .reserved_bank_bit_high(reserved_bank_bit_high),
        .indirect_bank_bit(indirect_bank_bit), .file_select_pointer(file_select_pointer),
        .use_indirect(use_indirect), .dir_addr(dir_addr), .d_rd(d_rd), .d_wr(d_wr), .d_wdata(d_wdata),
        .d_rdata(d_rdata), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata),
        .rsvd_bits_set(rsvd_bits_set));

    core_side_store core_side_store_i (.prog_addr(prog_addr), .sfr_addr(sfr_addr),
        .prog_rdata(prog_rdata), .sfr_rdata(sfr_rdata));

    // large variant, same stimulus
    memory_map_bank_decoder #(.LARGE(1'b1)) memory_map_bank_decoder_l_i (.core_clk(core_clk), .rst_n(rst_n),
        .pc_load(pc_load), .pc_load_val(pc_load_val), .pc_inc(pc_inc), .irq_take(irq_take),
        .prog_rdata(prog_rdata_l), .pc(pc_l), .prog_addr(prog_addr_l), .instr(instr_l),
        .bank_select_bit(bank_select_bit), .reserved_bank_bit_high(reserved_bank_bit_high),
        .indirect_bank_bit(indirect_bank_bit), .file_select_pointer(file_select_pointer),
        .use_indirect(use_indirect), .dir_addr(dir_addr), .d_rd(d_rd), .d_wr(d_wr), .d_wdata(d_wdata),
        .d_rdata(d_rdata_l), .sfr_sel(sfr_sel_l), .sfr_addr(sfr_addr_l), .sfr_rdata(sfr_rdata_l),
        .rsvd_bits_set(rsvd_l));

    core_side_store core_side_store_l_i (.prog_addr(prog_addr_l), .sfr_addr(sfr_addr_l),
        .prog_rdata(prog_rdata_l), .sfr_rdata(sfr_rdata_l));

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one data access lasting a single cycle, entered at a falling edge;
    // strobes stay up so back-to-back calls never assign them twice at once
    task automatic acc(input logic ind, input logic bnk, input logic [7:0] a, input logic wr,
                       input logic [7:0] wd);
        use_indirect = ind;
        bank_select_bit = bnk;
        file_select_pointer = a;
        dir_addr = a[6:0];
        d_wr = wr;
        d_rd = !wr;
        d_wdata = wd;
        @(negedge core_clk);
    endtask

    task automatic t_prog();
        check(pc, 14'h0000);
        pc_inc = 1'b1;
        @(negedge core_clk);
        check(pc, 14'h0001);
        irq_take = 1'b1;                                      // irq wins over the advance
        @(negedge core_clk);
        irq_take = 1'b0;
        pc_inc = 1'b0;
        check(pc, 14'h0004);
        check(prog_addr, 14'h0004);
        pc_load = 1'b1;
        pc_load_val = 13'h1FFF;
        @(negedge core_clk);
        pc_load = 1'b0;
        check(pc, 14'h1FFF);
        check(prog_addr, 14'h03FF);
        check(prog_addr_l, 14'h07FF);
        @(negedge core_clk);
        check(instr, {3'h5, 11'h3FF});
        check(instr_l, {3'h5, 11'h7FF});
        $display("program test done");
    endtask

    task automatic t_data();
        acc(1'b0, 1'b0, 8'h45, 1'b1, 8'hA5);
        acc(1'b0, 1'b1, 8'h45, 1'b0, 8'h00);
        check(d_rdata, 14'h0000);
        acc(1'b0, 1'b0, 8'h45, 1'b0, 8'h00);
        check(d_rdata, 14'h00A5);
        acc(1'b0, 1'b1, 8'h75, 1'b1, 8'h5A);
        acc(1'b1, 1'b0, 8'h75, 1'b0, 8'h00);
        check(d_rdata, 14'h005A);
        acc(1'b1, 1'b0, 8'h45, 1'b0, 8'h00);
        check(d_rdata, 14'h00A5);
        acc(1'b0, 1'b0, 8'h20, 1'b1, 8'h11);
        acc(1'b0, 1'b0, 8'h20, 1'b0, 8'h00);
        check(d_rdata, 14'h0000);
        check(d_rdata_l, 14'h0011);
        acc(1'b0, 1'b1, 8'h60, 1'b1, 8'h77);
        acc(1'b0, 1'b0, 8'h20, 1'b0, 8'h00);
        check(d_rdata_l, 14'h0011);
        acc(1'b0, 1'b1, 8'h60, 1'b0, 8'h00);
        check(d_rdata_l, 14'h0077);
        check(d_rdata, 14'h0000);
        d_wr = 1'b0;
        d_rd = 1'b0;
        @(negedge core_clk);
        $display("data test done");
    endtask

    task automatic t_sfr();
        use_indirect = 1'b0;
        bank_select_bit = 1'b1;
        dir_addr = 7'h03;
        d_rd = 1'b1;
        #1;
        check(sfr_sel, 14'h0001);
        check(sfr_addr, 14'h0083);
        @(negedge core_clk);
        check(d_rdata, 14'h0040);
        bank_select_bit = 1'b0;
        dir_addr = 7'h20;
        #1;
        check(sfr_sel, 14'h0000);
        d_rd = 1'b0;
        reserved_bank_bit_high = 1'b1;
        #1;
        check(rsvd_bits_set, 14'h0001);
        reserved_bank_bit_high = 1'b0;
        #1;
        check(rsvd_bits_set, 14'h0000);
        $display("special register test done");
    endtask

    // hang guard, far above the few dozen cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 2000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        t_prog();
        t_data();
        t_sfr();
        complete_run();
    end
endmodule
